// *** rtl/ascal_regs.vh ***
// ascal_regs.vh: constants of the converter control block
// assumes inclusion by bare name from the rtl files of this block
`ifndef ASCAL_REGS_VH
`define ASCAL_REGS_VH

// serial command and reset pattern
`define ASCAL_CMD_EXIT       8'h42
`define ASCAL_RST_LEN        7'd64

// mode field codes
`define ASCAL_MODE_INT_OFS   4'h5
`define ASCAL_MODE_INT_GAIN  4'h6
`define ASCAL_MODE_SYS_OFS   4'h7
`define ASCAL_MODE_SYS_GAIN  4'h8

// coefficient reset values and scaling constants
`define ASCAL_ZERO_RST       24'h800000
`define ASCAL_SCALE_RST      24'h555555
`define ASCAL_MIDSCALE       24'h800000
`define ASCAL_UNI_SHIFT      6'd21
`define ASCAL_BIP_SHIFT      6'd22

// calibration length in first conversions, less one
`define ASCAL_IGAIN_CONVS    2'd3
`define ASCAL_OTHER_CONVS    2'd0

// output frame layout
`define ASCAL_DATA_BITS      6'd24
`define ASCAL_BYTE_BITS      6'd8
`define ASCAL_CRC_POLY       8'h07

// pin sampler bit positions and idle levels
`define ASCAL_P_SCLK         0
`define ASCAL_P_CSN          1
`define ASCAL_P_DIN          2
`define ASCAL_P_ALIGN        3
`define ASCAL_P_MCLK         4
`define ASCAL_PIN_IDLE       5'h0B

`endif

// *** rtl/ascal_mem.v ***
// ascal_mem.v: per-channel coefficient store, one write port, two read ports
// assumes write and reads on core_clk; read data registered
`timescale 1ns/100ps
`default_nettype none
module ascal_mem #(
  parameter W     = 24,
  parameter DEPTH = 4,
  parameter AW    = 2,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // clock and reset
  input  wire          clk,
  input  wire          resetn,
  input  wire          clr,
  // write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  // read ports
  input  wire [AW-1:0] ra_addr,
  output reg  [W-1:0]  ra_data,
  input  wire [AW-1:0] rb_addr,
  output reg  [W-1:0]  rb_data
);
  reg [W-1:0] mem [0:DEPTH-1];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : word
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          mem[g] <= RST;
        end else if (clr) begin
          mem[g] <= RST;
        end else if (we && waddr == g) begin
          mem[g] <= wdata;
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ra_data <= {W{1'b0}};
      rb_data <= {W{1'b0}};
    end else begin
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
    end
  end
endmodule
`default_nettype wire

// *** rtl/ascal_scale.v ***
// ascal_scale.v: offset and gain scaling of one raw result, one cycle
// assumes 24-bit raw code and coefficients valid with in_valid
`timescale 1ns/100ps
`default_nettype none
`include "ascal_regs.vh"
module ascal_scale (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // operands
  input  wire        in_valid,
  input  wire        bipolar,
  input  wire [23:0] raw,
  input  wire [23:0] zero_coeff,
  input  wire [23:0] scale_coeff,
  // result
  output reg         out_valid,
  output reg  [23:0] out_data
);
  wire signed [25:0] ofs  = $signed({2'b00, zero_coeff}) - $signed({2'b00, `ASCAL_MIDSCALE});
  wire signed [25:0] diff = $signed({2'b00, raw}) - ofs;
  wire signed [51:0] prod = diff * $signed({2'b00, scale_coeff});
  wire signed [51:0] uni  = prod >>> `ASCAL_UNI_SHIFT;
  wire signed [51:0] bip  = (prod >>> `ASCAL_BIP_SHIFT) + $signed({28'h0, `ASCAL_MIDSCALE});
  wire signed [51:0] res  = bipolar ? bip : uni;
  // clamp to the 24-bit code range
  wire [23:0] sat = res[51] ? 24'h000000 :
                    (|res[50:24]) ? 24'hFFFFFF : res[23:0];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data  <= 24'h000000;
    end else begin
      out_valid <= in_valid;
      out_data  <= sat;
    end
  end
endmodule
`default_nettype wire

// *** rtl/ascal_ctrl.v ***
// ascal_ctrl.v: streaming read, align pin and calibration control
// assumes pins are asynchronous to core_clk; raw results arrive on core_clk
// Operation
// - stream mode allows only data register reads
// - command 0x42 with ready low exits streaming
// - stream CRC presumes 0x42 before data
// - 64 clocks, CS low, DIN high: full reset
// - channels in turn, optional status byte appended
// - FIFO enabled disables streaming mode
// - align low resets conversion path only
// - align keeps interface, forces ready high
// - align sampled on main clock falling edges
// - align rising edge starts conversions
// - clear-FIFO option replaces path reset
// - results scaled by channel coefficients
// - mode codes 5..8 start calibrations
// - no internal gain cal at unity, unbypassed
// - cal start: ready high, pending flag set
// - cal end: coefficient, flag clear, ready low only if CS low
// - unipolar doubles, bipolar adds midscale
// - coefficients host access except during cal
// - background checks during cal set error
// - internal gain cal four conversions
// - ignore SCLK until ready falls
`timescale 1ns/100ps
`default_nettype none
`include "ascal_regs.vh"
module ascal_ctrl #(
  parameter NCH             = 4,
  parameter CHW             = 2,
  parameter FIRST_CONV_MCLK = 16'd1024,
  parameter [23:0] FACTORY_SCALE = `ASCAL_SCALE_RST
) (
  // clock and reset
  input  wire           core_clk,
  input  wire           resetn,
  // serial pins
  input  wire           sclk,
  input  wire           cs_n,
  input  wire           din,
  output reg            dout_q,
  output reg            dout_oe_n_q,
  // main clock and align pin
  input  wire           mclk,
  input  wire           align_pin_n,
  // configuration
  input  wire           stream_read_en,
  input  wire           fifo_en,
  input  wire           append_status_en,
  input  wire           crc_en,
  input  wire           align_pin_clears_fifo,
  input  wire           bipolar,
  input  wire           amp_bypass,
  input  wire           gain_is_one,
  input  wire           conv_err_check_en,
  // mode write
  input  wire           mode_wr,
  input  wire [3:0]     mode,
  input  wire [CHW-1:0] cal_chan,
  input  wire [23:0]    cal_meas,
  input  wire           conv_err_in,
  input  wire           conv_err_clr,
  // raw conversion results
  input  wire           raw_valid,
  input  wire [CHW-1:0] raw_chan,
  input  wire [23:0]    raw_code,
  // host coefficient access
  input  wire           coef_wr,
  input  wire           coef_rd,
  input  wire           coef_is_scale,
  input  wire [CHW-1:0] coef_chan,
  input  wire [23:0]    coef_wdata,
  output reg  [23:0]    coef_rdata_q,
  output reg            coef_ack_q,
  output reg            coef_refused_q,
  // status
  output reg            data_ready_n_q,
  output reg            result_pending_flag_n_q,
  output reg  [23:0]    data_q,
  output reg  [7:0]     status_q,
  output reg            stream_active_q,
  output reg            reg_access_en_q,
  output reg            soft_reset_q,
  output reg            conv_reset_q,
  output reg            conv_start_q,
  output reg            fifo_clear_q,
  output reg            cal_busy_q,
  output reg            cal_refused_q,
  output reg            conv_err_flag_q,
  output reg  [CHW-1:0] cal_active_chan_q
);
  localparam CAL_IDLE = 2'd0;
  localparam CAL_RUN  = 2'd1;
  localparam CAL_DONE = 2'd2;

  function is_cal;
    input [3:0] m;
    begin
      is_cal = (m == `ASCAL_MODE_INT_OFS) || (m == `ASCAL_MODE_INT_GAIN) ||
               (m == `ASCAL_MODE_SYS_OFS) || (m == `ASCAL_MODE_SYS_GAIN);
    end
  endfunction

  function is_gain;
    input [3:0] m;
    begin
      is_gain = (m == `ASCAL_MODE_INT_GAIN) || (m == `ASCAL_MODE_SYS_GAIN);
    end
  endfunction

  function [7:0] crc8;
    input [39:0] msg;
    input [5:0]  nbits;
    integer i;
    reg [7:0] c;
    reg       fb;
    begin
      c = 8'h00;
      for (i = 0; i < 40; i = i + 1) begin
        if (i < nbits) begin
          fb = c[7] ^ msg[39-i];
          c  = {c[6:0], 1'b0} ^ (fb ? `ASCAL_CRC_POLY : 8'h00);
        end
      end
      crc8 = c;
    end
  endfunction

  // three-stage pin samplers
  reg [4:0] s1_q, s2_q, s3_q, st_q;
  wire [4:0] agree   = ~(s2_q ^ s3_q);
  wire [4:0] rise    = agree & s3_q & ~st_q;
  wire [4:0] fall    = agree & ~s3_q & st_q;
  wire       sclk_r  = rise[`ASCAL_P_SCLK];
  wire       sclk_f  = fall[`ASCAL_P_SCLK];
  wire       cs_low  = ~st_q[`ASCAL_P_CSN];
  wire       din_s   = st_q[`ASCAL_P_DIN];
  wire       mclk_f  = fall[`ASCAL_P_MCLK];

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= `ASCAL_PIN_IDLE;
      s2_q <= `ASCAL_PIN_IDLE;
      s3_q <= `ASCAL_PIN_IDLE;
      st_q <= `ASCAL_PIN_IDLE;
    end else begin
      s1_q <= {mclk, align_pin_n, din, cs_n, sclk};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (agree & s3_q) | (~agree & st_q);
    end
  end

  // align pin on main clock falling edges
  reg  align_q;
  wire align_fall = mclk_f & align_q & ~st_q[`ASCAL_P_ALIGN];
  wire align_rise = mclk_f & ~align_q & st_q[`ASCAL_P_ALIGN];

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      align_q      <= 1'b1;
      conv_reset_q <= 1'b0;
      conv_start_q <= 1'b0;
      fifo_clear_q <= 1'b0;
    end else begin
      if (mclk_f) begin
        align_q <= st_q[`ASCAL_P_ALIGN];
      end
      fifo_clear_q <= align_fall & align_pin_clears_fifo;
      conv_start_q <= align_rise & ~align_pin_clears_fifo;
      if (soft_reset_q || align_rise) begin
        conv_reset_q <= 1'b0;
      end else if (align_fall && !align_pin_clears_fifo) begin
        conv_reset_q <= 1'b1;
      end
    end
  end

  // calibration sequencer
  reg  [1:0]     cal_st_q;
  reg  [3:0]     cal_mode_q;
  reg  [17:0]    cal_cnt_q;
  reg  [17:0]    cal_len_q;
  wire           cal_go   = mode_wr && is_cal(mode) && cal_st_q == CAL_IDLE;
  wire           cal_bad  = (mode == `ASCAL_MODE_INT_GAIN) && gain_is_one && !amp_bypass;
  wire           cal_done = cal_st_q == CAL_DONE;
  wire [1:0]     conv_mul = (mode == `ASCAL_MODE_INT_GAIN) ? `ASCAL_IGAIN_CONVS
                                                           : `ASCAL_OTHER_CONVS;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cal_st_q          <= CAL_IDLE;
      cal_mode_q        <= 4'h0;
      cal_cnt_q         <= 18'h00000;
      cal_len_q         <= 18'h00000;
      cal_busy_q        <= 1'b0;
      cal_refused_q     <= 1'b0;
      cal_active_chan_q <= {CHW{1'b0}};
    end else if (soft_reset_q) begin
      cal_st_q      <= CAL_IDLE;
      cal_busy_q    <= 1'b0;
      cal_refused_q <= 1'b0;
    end else begin
      cal_refused_q <= cal_go && cal_bad;
      case (cal_st_q)
        CAL_IDLE: begin
          cal_busy_q <= 1'b0;
          if (cal_go && !cal_bad && !conv_reset_q) begin
            cal_st_q          <= CAL_RUN;
            cal_busy_q        <= 1'b1;
            cal_mode_q        <= mode;
            cal_active_chan_q <= cal_chan;
            cal_cnt_q         <= 18'h00000;
            cal_len_q         <= FIRST_CONV_MCLK * ({16'h0000, conv_mul} + 18'd1);
          end
        end
        CAL_RUN: begin
          if (conv_reset_q) begin
            cal_st_q <= CAL_IDLE;
          end else if (mclk_f) begin
            cal_cnt_q <= cal_cnt_q + 18'd1;
            if (cal_cnt_q == cal_len_q - 18'd1) begin
              cal_st_q <= CAL_DONE;
            end
          end
        end
        CAL_DONE: begin
          cal_st_q <= CAL_IDLE;
        end
        default: begin
          cal_st_q <= CAL_IDLE;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conv_err_flag_q <= 1'b0;
    end else if (soft_reset_q) begin
      conv_err_flag_q <= 1'b0;
    end else if (cal_busy_q && conv_err_check_en && conv_err_in) begin
      conv_err_flag_q <= 1'b1;
    end else if (conv_err_clr) begin
      conv_err_flag_q <= 1'b0;
    end
  end

  // coefficient stores and host access
  wire           host_wr    = coef_wr && !cal_busy_q;
  wire           host_rd    = coef_rd && !cal_busy_q;
  wire           zero_we    = cal_done ? !is_gain(cal_mode_q) : host_wr && !coef_is_scale;
  wire           scale_we   = cal_done ? is_gain(cal_mode_q) : host_wr && coef_is_scale;
  wire [CHW-1:0] wr_chan    = cal_done ? cal_active_chan_q : coef_chan;
  wire [23:0]    wr_data    = cal_done ? cal_meas : coef_wdata;
  wire [23:0]    zero_ra, zero_rb, scale_ra, scale_rb;
  reg  [1:0]     rd_pipe_q;
  reg            rd_scale_q;

  ascal_mem #(.W(24), .DEPTH(NCH), .AW(CHW), .RST(`ASCAL_ZERO_RST)) u_zero (
    .clk     (core_clk),
    .resetn  (resetn),
    .clr     (soft_reset_q),
    .we      (zero_we),
    .waddr   (wr_chan),
    .wdata   (wr_data),
    .ra_addr (raw_chan),
    .ra_data (zero_ra),
    .rb_addr (coef_chan),
    .rb_data (zero_rb)
  );

  ascal_mem #(.W(24), .DEPTH(NCH), .AW(CHW), .RST(FACTORY_SCALE)) u_scale (
    .clk     (core_clk),
    .resetn  (resetn),
    .clr     (soft_reset_q),
    .we      (scale_we),
    .waddr   (wr_chan),
    .wdata   (wr_data),
    .ra_addr (raw_chan),
    .ra_data (scale_ra),
    .rb_addr (coef_chan),
    .rb_data (scale_rb)
  );

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_pipe_q      <= 2'b00;
      rd_scale_q     <= 1'b0;
      coef_rdata_q   <= 24'h000000;
      coef_ack_q     <= 1'b0;
      coef_refused_q <= 1'b0;
    end else begin
      rd_pipe_q      <= {1'b0, host_rd};
      rd_scale_q     <= coef_is_scale;
      coef_ack_q     <= rd_pipe_q[0] | (host_wr && !cal_done);
      coef_refused_q <= (coef_wr || coef_rd) && cal_busy_q;
      if (rd_pipe_q[0]) begin
        coef_rdata_q <= rd_scale_q ? scale_rb : zero_rb;
      end
    end
  end

  // scaling path
  reg            raw_v_q;
  reg  [23:0]    raw_code_q;
  reg  [CHW-1:0] raw_chan_q, sc_chan_q;
  wire           sc_valid;
  wire [23:0]    sc_data;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      raw_v_q    <= 1'b0;
      raw_code_q <= 24'h000000;
      raw_chan_q <= {CHW{1'b0}};
      sc_chan_q  <= {CHW{1'b0}};
    end else begin
      raw_v_q    <= raw_valid && !conv_reset_q && !cal_busy_q && !soft_reset_q;
      raw_code_q <= raw_code;
      raw_chan_q <= raw_chan;
      sc_chan_q  <= raw_chan_q;
    end
  end

  ascal_scale u_scale_math (
    .clk         (core_clk),
    .resetn      (resetn),
    .in_valid    (raw_v_q),
    .bipolar     (bipolar),
    .raw         (raw_code_q),
    .zero_coeff  (zero_ra),
    .scale_coeff (scale_ra),
    .out_valid   (sc_valid),
    .out_data    (sc_data)
  );

  // result frame, ready and streaming interface
  reg  [39:0] frame_q;
  reg  [5:0]  frame_bits_q;
  reg  [5:0]  bit_cnt_q;
  reg  [7:0]  cmd_q;
  reg  [2:0]  cmd_cnt_q;
  reg  [6:0]  rst_cnt_q;
  reg         stream_block_q;
  wire [7:0]  stat_w   = {conv_err_flag_q, {(7-CHW){1'b0}}, sc_chan_q};
  wire [39:0] crc_msg  = {`ASCAL_CMD_EXIT, sc_data, stat_w};
  wire [5:0]  crc_n    = append_status_en ? 6'd40 : 6'd32;
  wire [7:0]  crc_w    = crc8(crc_msg, crc_n);
  wire        rd_clk   = stream_active_q && cs_low && !data_ready_n_q;
  wire        rd_last  = rd_clk && sclk_r && (bit_cnt_q == frame_bits_q - 6'd1);
  wire [7:0]  cmd_next = {cmd_q[6:0], din_s};
  wire        exit_cmd = rd_clk && sclk_r && cmd_cnt_q == 3'd7 &&
                         cmd_next == `ASCAL_CMD_EXIT;
  wire        load     = sc_valid && !conv_reset_q;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt_q    <= 7'd0;
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= 1'b0;
      if (!cs_low) begin
        rst_cnt_q <= 7'd0;
      end else if (sclk_r) begin
        if (!din_s) begin
          rst_cnt_q <= 7'd0;
        end else if (rst_cnt_q == `ASCAL_RST_LEN - 7'd1) begin
          rst_cnt_q    <= 7'd0;
          soft_reset_q <= 1'b1;
        end else begin
          rst_cnt_q <= rst_cnt_q + 7'd1;
        end
      end
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stream_block_q  <= 1'b0;
      stream_active_q <= 1'b0;
      reg_access_en_q <= 1'b1;
    end else begin
      if (soft_reset_q || exit_cmd) begin
        stream_block_q <= 1'b1;
      end else if (!stream_read_en) begin
        stream_block_q <= 1'b0;
      end
      stream_active_q <= stream_read_en && !fifo_en && !stream_block_q &&
                         !soft_reset_q && !exit_cmd;
      reg_access_en_q <= !(stream_read_en && !fifo_en && !stream_block_q);
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_ready_n_q          <= 1'b1;
      result_pending_flag_n_q <= 1'b1;
      data_q                  <= 24'h000000;
      status_q                <= 8'h00;
      frame_q                 <= 40'h0000000000;
      frame_bits_q            <= `ASCAL_DATA_BITS;
      bit_cnt_q               <= 6'd0;
      cmd_q                   <= 8'h00;
      cmd_cnt_q               <= 3'd0;
    end else if (soft_reset_q) begin
      data_ready_n_q          <= 1'b1;
      result_pending_flag_n_q <= 1'b1;
      bit_cnt_q               <= 6'd0;
      cmd_cnt_q               <= 3'd0;
    end else begin
      if (align_fall && !align_pin_clears_fifo) begin
        data_ready_n_q <= 1'b1;
      end else if (cal_go && !cal_bad) begin
        data_ready_n_q          <= 1'b1;
        result_pending_flag_n_q <= 1'b1;
      end else if (cal_done) begin
        result_pending_flag_n_q <= 1'b0;
        data_ready_n_q          <= !cs_low;
      end else if (load) begin
        data_ready_n_q          <= 1'b0;
        result_pending_flag_n_q <= 1'b0;
        data_q                  <= sc_data;
        status_q                <= stat_w;
        frame_q                 <= append_status_en ? {sc_data, stat_w, crc_w}
                                                    : {sc_data, crc_w, 8'h00};
        frame_bits_q            <= `ASCAL_DATA_BITS +
                                   (append_status_en ? `ASCAL_BYTE_BITS : 6'd0) +
                                   (crc_en ? `ASCAL_BYTE_BITS : 6'd0);
        bit_cnt_q               <= 6'd0;
        cmd_cnt_q               <= 3'd0;
      end else if (rd_last || exit_cmd) begin
        data_ready_n_q          <= 1'b1;
        result_pending_flag_n_q <= 1'b1;
      end
      if (rd_clk && sclk_r && !load) begin
        bit_cnt_q <= bit_cnt_q + 6'd1;
        cmd_q     <= cmd_next;
        cmd_cnt_q <= cmd_cnt_q + 3'd1;
      end
      if (rd_clk && sclk_f && !load && bit_cnt_q != 6'd0) begin
        frame_q <= {frame_q[38:0], 1'b0};
      end
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dout_q      <= 1'b1;
      dout_oe_n_q <= 1'b1;
    end else begin
      dout_oe_n_q <= !(stream_active_q && cs_low);
      dout_q      <= data_ready_n_q ? 1'b1 : frame_q[39];
    end
  end
endmodule
`default_nettype wire

// *** dv/ascal_ctrl_properties.sv ***
// ascal_ctrl_properties.sv: port timing checks for ascal_ctrl
// assumes bind into ascal_ctrl, single core_clk domain
`timescale 1ns/100ps
`default_nettype none
module ascal_ctrl_properties (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // inputs
  input wire logic       fifo_en,
  input wire logic       amp_bypass,
  input wire logic       gain_is_one,
  input wire logic       conv_err_check_en,
  input wire logic       conv_err_in,
  input wire logic       mode_wr,
  input wire logic [3:0] mode,
  input wire logic       coef_wr,
  // outputs
  input wire logic       coef_refused_q,
  input wire logic       data_ready_n_q,
  input wire logic       result_pending_flag_n_q,
  input wire logic       stream_active_q,
  input wire logic       reg_access_en_q,
  input wire logic       conv_reset_q,
  input wire logic       conv_start_q,
  input wire logic       cal_busy_q,
  input wire logic       cal_refused_q,
  input wire logic       conv_err_flag_q
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  chk_stream_only: assert property (
    stream_active_q |-> !reg_access_en_q) else $error("access open while streaming");
  chk_fifo_block: assert property (
    fifo_en && $past(fifo_en) && $past(fifo_en, 2) |-> !stream_active_q)
    else $error("streaming with fifo on");
  chk_align_ready: assert property (
    $rose(conv_reset_q) |-> data_ready_n_q) else $error("ready low in align reset");
  chk_align_start: assert property (
    $fell(conv_reset_q) |-> conv_start_q) else $error("no start on align release");
  chk_cal_start: assert property (
    $rose(cal_busy_q) |-> data_ready_n_q && result_pending_flag_n_q)
    else $error("cal start flags wrong");
  chk_gain_refuse: assert property (
    mode_wr && mode == 4'h6 && gain_is_one && !amp_bypass && !cal_busy_q && !conv_reset_q
    |=> cal_refused_q && !cal_busy_q) else $error("unity gain cal not refused");
  chk_coef_busy: assert property (
    coef_wr && cal_busy_q |=> coef_refused_q) else $error("coef write taken in cal");
  chk_cal_err: assert property (
    cal_busy_q && result_pending_flag_n_q && conv_err_check_en && conv_err_in && !conv_reset_q
    |=> conv_err_flag_q) else $error("cal error not flagged");
endmodule
bind ascal_ctrl ascal_ctrl_properties u_chk (.*);
`default_nettype wire

// *** dv/ascal_host.sv ***
// ascal_host.sv: host side of the serial link, sclk idles high
// assumes tasks called from the bench, 400 ns sclk period
`timescale 1ns/100ps
`default_nettype none
module ascal_host (
  // serial pins
  output var logic sclk,
  output var logic cs_n,
  output var logic din,
  // device outputs
  input wire logic dout_q,
  input wire logic data_ready_n_q
);
  initial {sclk, cs_n, din} = 3'b110;
  task automatic sel(input logic b);
    cs_n = b;
    #400;
  endtask
  // read n bits, cmd shifted on din over the first byte
  task automatic xfer(input int n, input logic [7:0] cmd, output logic [39:0] v);
    int i;
    v = '0;
    for (i = 0; i < 2000 && data_ready_n_q; i++) #50;
    for (i = 0; i < n; i++) begin
      din = (i < 8) ? cmd[7-i] : 1'b0;
      sclk = 1'b0;
      #200;
      sclk = 1'b1;
      #150;
      v = {v[38:0], dout_q};
      #50;
    end
    din = 1'b0;
  endtask
  task automatic sw_reset();
    din = 1'b1;
    repeat (64) begin
      sclk = 1'b0;
      #200;
      sclk = 1'b1;
      #200;
    end
    din = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/ascal_ctrl_tb.sv ***
// ascal_ctrl_tb.sv: self-checking bench for ascal_ctrl
// assumes ascal_host on the serial pins, checker bound to the design
`timescale 1ns/100ps
`default_nettype none
module ascal_ctrl_tb;
  logic core_clk, resetn, mclk, align_pin_n, stream_read_en, fifo_en, append_status_en;
  logic crc_en, align_pin_clears_fifo, bipolar, amp_bypass, gain_is_one, conv_err_check_en;
  logic mode_wr, conv_err_in, conv_err_clr, raw_valid, coef_wr, coef_rd, coef_is_scale;
  logic dout_q, dout_oe_n_q, coef_ack_q, coef_refused_q, data_ready_n_q, stream_active_q;
  logic result_pending_flag_n_q, reg_access_en_q, soft_reset_q, conv_reset_q, conv_start_q;
  logic fifo_clear_q, cal_busy_q, cal_refused_q, conv_err_flag_q;
  logic [3:0]  mode;
  logic [1:0]  cal_chan, raw_chan, coef_chan, cal_active_chan_q;
  logic [23:0] cal_meas, raw_code, coef_wdata, coef_rdata_q, data_q, d;
  logic [7:0]  status_q;
  logic [39:0] v;
  logic [3:0]  tbl [4] = '{4'h6, 4'h5, 4'h7, 4'h8};
  wire         sclk, cs_n, din;
  int failures, samples_checked, n_sr, n_cs, n_fc, n_rf, i, n, len [4], n_ak, n_rc;

  ascal_ctrl #(.FIRST_CONV_MCLK(16'd4)) u_ascal_ctrl (.*);
  ascal_host u_ascal_host (.*);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    mclk = 1'b0;
    #7 forever #100 mclk = ~mclk;
  end
  // pulse outputs counted for later checks
  always @(posedge core_clk) begin
    n_sr <= n_sr + soft_reset_q;
    n_cs <= n_cs + conv_start_q;
    n_fc <= n_fc + fifo_clear_q;
    n_rf <= n_rf + cal_refused_q;
    n_ak <= n_ak + coef_ack_q;
    n_rc <= n_rc + coef_refused_q;
  end

  function automatic [7:0] crc8(input [31:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 31; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ m[k]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string nm, input logic [39:0] e, input logic [39:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cw(input logic s, input logic [1:0] c, input logic [23:0] x);
    coef_is_scale = s;
    coef_chan = c;
    coef_wdata = x;
    coef_wr = 1'b1;
    tick(1);
    coef_wr = 1'b0;
    tick(2);
  endtask
  task automatic cr(input logic s, input logic [1:0] c);
    coef_is_scale = s;
    coef_chan = c;
    coef_rd = 1'b1;
    tick(1);
    coef_rd = 1'b0;
    tick(2);
    d = coef_rdata_q;
  endtask
  task automatic raw(input logic [23:0] x);
    raw_chan = 2'd1;
    raw_code = x;
    raw_valid = 1'b1;
    tick(1);
    raw_valid = 1'b0;
    tick(4);
  endtask
  task automatic cal_go(input logic [3:0] x);
    mode = x;
    mode_wr = 1'b1;
    tick(1);
    mode_wr = 1'b0;
    tick(1);
  endtask
  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    failures++;
    finish_test();
  end

  initial begin
    {resetn, stream_read_en, fifo_en, append_status_en, crc_en, align_pin_clears_fifo} = '0;
    {bipolar, amp_bypass, gain_is_one, conv_err_check_en, mode_wr, conv_err_in} = '0;
    {conv_err_clr, raw_valid, coef_wr, coef_rd, coef_is_scale} = '0;
    {mode, cal_chan, raw_chan, coef_chan, cal_meas, raw_code, coef_wdata} = '0;
    align_pin_n = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    tick(2);
    cr(0, 0);
    check("zero_rst", 24'h800000, d);
    cr(1, 0);
    check("scale_rst", 24'h555555, d);
    cw(0, 1, 24'h800000);
    cw(1, 1, 24'h400000);
    cr(1, 1);
    check("scale_wr", 24'h400000, d);
    for (i = 0; i < 2; i++) begin
      bipolar = i[0];
      raw(24'h100000);
      check("scaled", i ? 24'h900000 : 24'h200000, data_q);
      check("status", 8'h01, status_q);
    end
    bipolar = 1'b0;
    align_pin_n = 1'b0;
    tick(12);
    check("align_rst", 2'b11, {conv_reset_q, data_ready_n_q});
    align_pin_n = 1'b1;
    tick(12);
    check("align_run", {1'b0, 32'd1}, {conv_reset_q, n_cs});
    align_pin_clears_fifo = 1'b1;
    align_pin_n = 1'b0;
    tick(12);
    check("no_path_rst", 0, conv_reset_q);
    align_pin_n = 1'b1;
    tick(12);
    check("fifo_clr", 1, n_fc);
    align_pin_clears_fifo = 1'b0;
    u_ascal_host.sel(1'b0);
    stream_read_en = 1'b1;
    append_status_en = 1'b1;
    tick(4);
    check("reg_lock", 0, {reg_access_en_q, dout_oe_n_q});
    raw(24'h100000);
    u_ascal_host.xfer(32, 8'h00, v);
    check("frame_st", {24'h200000, 8'h01}, v);
    tick(8);
    check("rdy_after", 1, data_ready_n_q);
    append_status_en = 1'b0;
    crc_en = 1'b1;
    raw(24'h100000);
    u_ascal_host.xfer(32, 8'h00, v);
    check("frame_crc", {24'h200000, crc8({8'h42, 24'h200000})}, v);
    crc_en = 1'b0;
    raw(24'h100000);
    u_ascal_host.xfer(8, 8'h42, v);
    tick(8);
    check("exit", 0, stream_active_q);
    stream_read_en = 1'b0;
    tick(2);
    stream_read_en = 1'b1;
    tick(4);
    u_ascal_host.sw_reset();
    tick(8);
    check("sw_rst", {1'b0, 32'd1}, {stream_active_q, n_sr});
    stream_read_en = 1'b0;
    tick(2);
    stream_read_en = 1'b1;
    fifo_en = 1'b1;
    tick(4);
    check("fifo_blk", 0, stream_active_q);
    {stream_read_en, fifo_en} = 2'b00;
    conv_err_check_en = 1'b1;
    gain_is_one = 1'b1;
    cal_chan = 2'd2;
    cal_go(4'h6);
    check("refused", {1'b0, 32'd1}, {cal_busy_q, n_rf});
    gain_is_one = 1'b0;
    cw(0, 2, 24'h800000);
    for (i = 0; i < 4; i++) begin
      cal_meas = {20'h0A000, tbl[i]};
      cal_go(tbl[i]);
      check("cal_flags", 5'h1E, {cal_busy_q, data_ready_n_q, result_pending_flag_n_q,
                                 cal_active_chan_q});
      if (i == 0) begin
        conv_err_in = 1'b1;
        cw(0, 2, 24'h000123);
        conv_err_in = 1'b0;
      end
      for (n = 0; n < 2000 && cal_busy_q; n++) tick(1);
      len[i] = n;
      check("cal_done", 0, {result_pending_flag_n_q, data_ready_n_q});
      cr(tbl[i] == 4'h6 || tbl[i] == 4'h8, 2'd2);
      check("cal_coef", cal_meas, d);
      if (i == 0) begin
        cr(0, 2);
        check("refuse_wr", 24'h800000, d);
      end
    end
    check("cal_len", 1, (len[0] - len[1] > 38) && (len[0] - len[1] < 58));
    check("cal_err", 1, conv_err_flag_q);
    check("coef_hs", 16'h010B, {n_rc[7:0], n_ak[7:0]});
    finish_test();
  end
endmodule
`default_nettype wire
